// [pkg/rsf_pkg.sv]
// constants, field layouts and types for the regulator status flag block
// assumes a 25 MHz core clock and a separate serial link clock
package rsf_pkg;

  // core clock and overload timing
  localparam int CLK_HZ = 25_000_000;
  localparam int OC_TIME_MS = 48;
  localparam int MS_PER_S = 1000;
  localparam int OC_HOLD_CYC = (OC_TIME_MS * CLK_HZ) / MS_PER_S;
  localparam int OC_CNT_W = 21;

  // status register geometry
  localparam int STAT_W = 8;
  localparam int SYNC_STAGES = 2;

  // primary status byte fields
  localparam int P_OFF_BIT = 0;
  localparam int P_OVL_BIT = 2;
  localparam int P_LOW_BIT = 4;
  localparam int P_HOT_BIT = 6;
  localparam int P_SUP_BIT = 7;

  // secondary status byte fields
  localparam int S_COAX_BIT = 0;
  localparam int S_TONE_BIT = 2;

  // reset values: output off and level low
  localparam logic [7:0] PRI_RST = 8'h11;
  localparam logic [7:0] SEC_RST = 8'h00;
  localparam logic [7:0] STAT_ZERO = 8'h00;

  // positions in the synchronised sensor bundle
  localparam int IN_OVC = 0;
  localparam int IN_HOT = 1;
  localparam int IN_VLOW = 2;
  localparam int IN_B85 = 3;
  localparam int IN_W90 = 4;
  localparam int IN_A21 = 5;
  localparam int IN_B1995 = 6;
  localparam int IN_TOUT = 7;
  localparam int IN_TRX = 8;
  localparam int N_SENSE = 9;

  // positions in the synchronised link bundle
  localparam int LK_FRAME = 0;
  localparam int LK_UPD = 1;
  localparam int N_LINK = 2;

  // link byte sequencing
  localparam int BIT_CNT_W = 3;
  localparam logic [2:0] LK_FIRST_CNT = 3'h1;
  localparam logic [2:0] LK_LAST_BIT = 3'h7;
  localparam logic [2:0] LK_CNT_ZERO = 3'h0;
  localparam logic [2:0] LK_MSB = 3'h7;
  localparam logic SEL_PRI = 1'b0;

  typedef enum logic [2:0] {
    LK_IDLE = 3'b001,
    LK_DATA = 3'b010,
    LK_ACK = 3'b100
  } rsf_lk_st_t;

endpackage

// [pkg/rsf_link_if.sv]
// carrier between the status core and the serial link byte engine
// status bytes are quasi-static: the core freezes them during a read frame
`timescale 1ns/1ns
interface rsf_link_if;
  logic [7:0] pri_sh;
  logic [7:0] sec_sh;
  logic upd_tgl;

  modport core (
    output pri_sh,
    output sec_sh,
    input upd_tgl
  );

  modport link (
    input pri_sh,
    input sec_sh,
    output upd_tgl
  );
endinterface

// [verilog/rsf_sync.sv]
// bank of two-stage level synchronisers
// assumes each bit is a slow level from another domain or a pin
`timescale 1ns/1ns
module rsf_sync
  import rsf_pkg::*;
#(
  parameter int W = 1
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // levels in and out
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);

  logic [W-1:0] meta_r;
  logic [W-1:0] q_r;

  // first stage feeds only the second
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_r <= '0;
      q_r <= '0;
    end else begin
      meta_r <= d;
      q_r <= meta_r;
    end
  end

  assign q = q_r;

endmodule

// [verilog/rsf_link.sv]
// serial read byte engine on the link clock
// assumes the transaction engine raises rd_frame for the data phase of a read
`timescale 1ns/1ns
module rsf_link
  import rsf_pkg::*;
(
  // link clock and reset
  input wire logic link_clk,
  input wire logic rst_n,
  // frame and data pin
  input wire logic rd_frame,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe,
  // core side
  rsf_link_if.link lk
);

  rsf_lk_st_t st_r;
  logic [2:0] cnt_r;
  logic sel_r;
  logic tgl_r;
  logic oe_r;
  logic [7:0] cur_byte;
  logic frame_rst_n;

  assign cur_byte = (sel_r == SEL_PRI) ? lk.pri_sh : lk.sec_sh; // RULE_21

  // clock may park high after a frame: frame end alone restarts the byte order
  assign frame_rst_n = rst_n & rd_frame;

  // ninth rising edge: status update event for the core
  always_ff @(posedge link_clk or negedge rst_n) begin
    if (!rst_n) begin
      tgl_r <= 1'b0;
    end else if (st_r == LK_ACK) begin
      tgl_r <= ~tgl_r; // RULE_05
    end
  end

  // bit sequencing on rising edges
  always_ff @(posedge link_clk or negedge frame_rst_n) begin
    if (!frame_rst_n) begin
      st_r <= LK_IDLE;
      cnt_r <= LK_CNT_ZERO;
      sel_r <= SEL_PRI; // RULE_21
    end else begin
      unique case (st_r)
        LK_IDLE: begin
          st_r <= LK_DATA;
          cnt_r <= LK_FIRST_CNT;
        end
        LK_DATA: begin
          if (cnt_r == LK_LAST_BIT) begin
            st_r <= LK_ACK;
            cnt_r <= LK_CNT_ZERO;
          end else begin
            cnt_r <= cnt_r + LK_FIRST_CNT;
          end
        end
        LK_ACK: begin
          // ninth rising edge: next register
          sel_r <= ~sel_r; // RULE_21
          st_r <= sda_i ? LK_IDLE : LK_IDLE;
        end
      endcase
    end
  end

  // open-drain data changes only while the clock is low
  // a cut frame releases the wire at once, clock or not
  always_ff @(negedge link_clk or negedge frame_rst_n) begin
    if (!frame_rst_n) begin
      oe_r <= 1'b0;
    end else if (rd_frame && st_r == LK_IDLE) begin
      oe_r <= ~cur_byte[LK_MSB];
    end else if (rd_frame && st_r == LK_DATA) begin
      oe_r <= ~cur_byte[LK_MSB - cnt_r];
    end else begin
      oe_r <= 1'b0;
    end
  end

  assign sda_o = 1'b0;
  assign sda_oe = oe_r;
  assign lk.upd_tgl = tgl_r;

endmodule

// [verilog/rsf_core.sv]
// regulator status flags: fault latching, output control and status bytes
// assumes control bits and write completion come from logic on clk;
// sensor comparators are asynchronous levels; link logic runs on link_clk
`timescale 1ns/1ns

////////////////////////////////////////////////////////////////////////////////

// Overview of operation
// RULE_01: output-off flag, primary bit 0, sets at power-on and on any fault.
// RULE_02: interrupt request never raised just because output-off flag sets.
// RULE_03: host write that leaves output enabled clears the output-off flag; here only with no fault present and all latched faults read away.
// RULE_04: overcurrent beyond 48 ms switches output off, sets overload and off flags.
// RULE_05: ninth read clock updates status and always clears the overload flag; here an overload trip in the same core cycle keeps it set.
// RULE_06: level-low flag, bit 4, sets when output is below 85 percent.
// RULE_07: level-low clears once output is within 90 percent; not latched.
// RULE_08: level-low evaluated continuously and reads 1 while output disabled.
// RULE_09: overtemperature switches output off, sets overheat bit 6 and off flag.
// RULE_10: ninth read clock samples overtemperature: clear if gone, else keep.
// RULE_11: input undervoltage locks output off, sets bit 7 and off flag.
// RULE_12: after lockout output stays off until host writes output-enable again.
// RULE_13: ninth read clock samples undervoltage: clear if gone, else keep.
// RULE_14: secondary byte: coax-open bit 0, tone-seen bit 2, rest unused.
// RULE_15: coax test disables linear regulator and enables 1 mA source.
// RULE_16: during coax test, coax-open flag sets when output exceeds 21 V.
// RULE_17: coax-open flag clears below 19.95 V without a status read.
// RULE_18: tone-seen sets when tone at output, local or from far end.
// RULE_19: tone-seen clears when local tone off and nothing received.
// RULE_20: overload, overheat and supply-low stay latched until read after clearing.
// RULE_21: multi-byte read alternates primary, secondary; each read starts primary.
// RULE_22: host starts coax test by writing test, enable and level bits.
// RULE_23: unused status bits read zero; healthy device reads all zeros.
module rsf_core
  import rsf_pkg::*;
#(
  parameter int OC_HOLD = OC_HOLD_CYC
) (
  // core clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // serial link
  input wire logic link_clk,
  input wire logic rd_frame,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe,
  // control bits from the write side
  input wire logic ctl_write_done,
  input wire logic output_on_ctl,
  input wire logic coax_test_ctl,
  input wire logic tone_local_en,
  // sensor comparators
  input wire logic ovc_cmp,
  input wire logic hot_cmp,
  input wire logic vin_low_cmp,
  input wire logic below85_cmp,
  input wire logic within90_cmp,
  input wire logic above21_cmp,
  input wire logic below1995_cmp,
  input wire logic tone_out_cmp,
  input wire logic tone_rx_cmp,
  // power stage controls
  output logic feed_output_en,
  output logic linear_reg_en,
  output logic coax_src_en,
  // fault request and status view
  output logic fault_irq,
  output logic [7:0] fault_status_primary,
  output logic [7:0] fault_status_secondary
);

  //////////////////////////////////////////////////////////////////////////////
  // helpers

  // any latched fault flag still standing
  function automatic logic latched_any(input logic a, input logic b, input logic c);
    latched_any = a | b | c;
  endfunction

  //////////////////////////////////////////////////////////////////////////////
  // declarations

  rsf_link_if lk ();
  logic [N_SENSE-1:0] sense_raw, sense_s;
  logic [N_LINK-1:0] link_raw, link_s;
  logic ovc_s, hot_s, vlow_s, b85_s, w90_s, a21_s, b1995_s, tout_s, trx_s;
  logic frame_s, upd_s, upd_d_r, upd_p;
  logic [OC_CNT_W-1:0] oc_cnt_r;
  logic ovl_hit, fault_now, rearm_ok;
  logic output_off_flag_r, overload_flag_r, level_low_flag_r, overheat_flag_r;
  logic supply_low_flag_r, coax_open_flag_r, tone_seen_flag_r;
  logic trip_r, feed_en_r, lin_en_r, src_en_r, irq_r;
  logic [7:0] pri_nxt, sec_nxt, pri_r, sec_r, pri_sh_r, sec_sh_r;

  //////////////////////////////////////////////////////////////////////////////
  // synchronisers

  assign sense_raw[IN_OVC] = ovc_cmp;
  assign sense_raw[IN_HOT] = hot_cmp;
  assign sense_raw[IN_VLOW] = vin_low_cmp;
  assign sense_raw[IN_B85] = below85_cmp;
  assign sense_raw[IN_W90] = within90_cmp;
  assign sense_raw[IN_A21] = above21_cmp;
  assign sense_raw[IN_B1995] = below1995_cmp;
  assign sense_raw[IN_TOUT] = tone_out_cmp;
  assign sense_raw[IN_TRX] = tone_rx_cmp;

  rsf_sync #(
    .W(N_SENSE)
  ) u_sense_sync (
    .clk(clk),
    .rst_n(rst_n),
    .d(sense_raw),
    .q(sense_s)
  );

  assign link_raw[LK_FRAME] = rd_frame;
  assign link_raw[LK_UPD] = lk.upd_tgl;

  rsf_sync #(
    .W(N_LINK)
  ) u_link_sync (
    .clk(clk),
    .rst_n(rst_n),
    .d(link_raw),
    .q(link_s)
  );

  assign ovc_s = sense_s[IN_OVC];
  assign hot_s = sense_s[IN_HOT];
  assign vlow_s = sense_s[IN_VLOW];
  assign b85_s = sense_s[IN_B85];
  assign w90_s = sense_s[IN_W90];
  assign a21_s = sense_s[IN_A21];
  assign b1995_s = sense_s[IN_B1995];
  assign tout_s = sense_s[IN_TOUT];
  assign trx_s = sense_s[IN_TRX];
  assign frame_s = link_s[LK_FRAME];
  assign upd_s = link_s[LK_UPD];

  //////////////////////////////////////////////////////////////////////////////
  // ninth-clock update event from the link domain

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      upd_d_r <= 1'b0;
    end else begin
      upd_d_r <= upd_s;
    end
  end

  assign upd_p = upd_s ^ upd_d_r;

  //////////////////////////////////////////////////////////////////////////////
  // overcurrent persistence timer

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      oc_cnt_r <= '0;
    end else if (!ovc_s || !feed_en_r) begin
      oc_cnt_r <= '0;
    end else if (!ovl_hit) begin
      oc_cnt_r <= oc_cnt_r + OC_CNT_W'(1);
    end
  end

  assign ovl_hit = ovc_s && feed_en_r && (oc_cnt_r == OC_CNT_W'(OC_HOLD - 1)); // RULE_04

  assign fault_now = ovl_hit | hot_s | vlow_s;

  // re-enable needs a host write with all latched faults already read away
  assign rearm_ok = ctl_write_done && output_on_ctl && !fault_now &&
    !latched_any(overload_flag_r, overheat_flag_r, supply_low_flag_r); // RULE_12

  //////////////////////////////////////////////////////////////////////////////
  // latched fault flags; a new fault beats the read clear

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      overload_flag_r <= 1'b0;
    end else if (ovl_hit) begin
      overload_flag_r <= 1'b1; // RULE_04
    end else if (upd_p) begin
      overload_flag_r <= 1'b0; // RULE_05
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      overheat_flag_r <= 1'b0;
    end else if (hot_s) begin
      overheat_flag_r <= 1'b1; // RULE_09
    end else if (upd_p) begin
      overheat_flag_r <= 1'b0; // RULE_10 RULE_20
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      supply_low_flag_r <= 1'b0;
    end else if (vlow_s) begin
      supply_low_flag_r <= 1'b1; // RULE_11
    end else if (upd_p) begin
      supply_low_flag_r <= 1'b0; // RULE_13 RULE_20
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // output lockout and output-off flag

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      trip_r <= 1'b0;
    end else if (fault_now) begin
      trip_r <= 1'b1; // RULE_04 RULE_09 RULE_11
    end else if (rearm_ok) begin
      trip_r <= 1'b0; // RULE_12
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      output_off_flag_r <= 1'b1; // RULE_01
    end else if (fault_now) begin
      output_off_flag_r <= 1'b1; // RULE_01
    end else if (ctl_write_done && !output_on_ctl) begin
      output_off_flag_r <= 1'b1;
    end else if (rearm_ok) begin
      output_off_flag_r <= 1'b0; // RULE_03
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      feed_en_r <= 1'b0;
    end else begin
      feed_en_r <= output_on_ctl && !trip_r && !fault_now;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // coax disconnect test drive

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      lin_en_r <= 1'b0;
      src_en_r <= 1'b0;
    end else begin
      lin_en_r <= output_on_ctl && !trip_r && !fault_now && !coax_test_ctl; // RULE_15
      src_en_r <= output_on_ctl && !trip_r && !fault_now && coax_test_ctl; // RULE_15
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // non-latched condition flags

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      level_low_flag_r <= 1'b1; // RULE_08
    end else if (!feed_en_r || b85_s) begin
      level_low_flag_r <= 1'b1; // RULE_06 RULE_08
    end else if (w90_s) begin
      level_low_flag_r <= 1'b0; // RULE_07
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      coax_open_flag_r <= 1'b0;
    end else if (!coax_test_ctl || b1995_s) begin
      coax_open_flag_r <= 1'b0; // RULE_17
    end else if (a21_s) begin
      coax_open_flag_r <= 1'b1; // RULE_16
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      tone_seen_flag_r <= 1'b0;
    end else if (tout_s && (tone_local_en || trx_s)) begin
      tone_seen_flag_r <= 1'b1; // RULE_18
    end else if (!tone_local_en && !trx_s) begin
      tone_seen_flag_r <= 1'b0; // RULE_19
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // fault request: latched faults only, never the output-off flag

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      irq_r <= 1'b0;
    end else begin
      irq_r <= latched_any(overload_flag_r, overheat_flag_r, supply_low_flag_r); // RULE_02
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // status bytes

  always_comb begin
    pri_nxt = STAT_ZERO; // RULE_23
    pri_nxt[P_OFF_BIT] = output_off_flag_r;
    pri_nxt[P_OVL_BIT] = overload_flag_r;
    pri_nxt[P_LOW_BIT] = level_low_flag_r;
    pri_nxt[P_HOT_BIT] = overheat_flag_r;
    pri_nxt[P_SUP_BIT] = supply_low_flag_r;
  end

  always_comb begin
    sec_nxt = STAT_ZERO; // RULE_23
    sec_nxt[S_COAX_BIT] = coax_open_flag_r; // RULE_14
    sec_nxt[S_TONE_BIT] = tone_seen_flag_r; // RULE_14
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pri_r <= PRI_RST;
      sec_r <= SEC_RST;
    end else begin
      pri_r <= pri_nxt;
      sec_r <= sec_nxt;
    end
  end

  // link copy frozen while a read frame is open
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pri_sh_r <= PRI_RST;
      sec_sh_r <= SEC_RST;
    end else if (!frame_s) begin
      pri_sh_r <= pri_r;
      sec_sh_r <= sec_r;
    end
  end

  assign lk.pri_sh = pri_sh_r;
  assign lk.sec_sh = sec_sh_r;

  //////////////////////////////////////////////////////////////////////////////
  // link byte engine

  rsf_link u_link (
    .link_clk(link_clk),
    .rst_n(rst_n),
    .rd_frame(rd_frame),
    .sda_i(sda_i),
    .sda_o(sda_o),
    .sda_oe(sda_oe),
    .lk(lk.link)
  );

  //////////////////////////////////////////////////////////////////////////////
  // outputs

  assign feed_output_en = feed_en_r;
  assign linear_reg_en = lin_en_r;
  assign coax_src_en = src_en_r;
  assign fault_irq = irq_r;
  assign fault_status_primary = pri_r;
  assign fault_status_secondary = sec_r;

endmodule

// [testbench/rsf_chk_checker.sv]
// checker for the regulator status flag block, bound to its top ports
// assumes sensor levels are held several core clocks between changes
`timescale 1ns/1ns
module rsf_chk
  import rsf_pkg::*;
#(
  parameter int OC_HOLD = OC_HOLD_CYC
) (
  // clocks and reset
  input wire logic clk,
  input wire logic rst_n,
  input wire logic link_clk,
  // link
  input wire logic rd_frame,
  input wire logic sda_oe,
  // sensors and controls
  input wire logic ovc_cmp,
  input wire logic hot_cmp,
  input wire logic below85_cmp,
  input wire logic within90_cmp,
  input wire logic above21_cmp,
  input wire logic below1995_cmp,
  input wire logic tone_out_cmp,
  input wire logic tone_rx_cmp,
  input wire logic tone_local_en,
  // outputs
  input wire logic feed_output_en,
  input wire logic linear_reg_en,
  input wire logic coax_src_en,
  input wire logic fault_irq,
  input wire logic [7:0] fault_status_primary,
  input wire logic [7:0] fault_status_secondary
);
  logic [7:0] pri;
  logic [7:0] sec;
  int oc_cnt_r;
  logic [3:0] bit_cnt_r;
  assign pri = fault_status_primary;
  assign sec = fault_status_secondary;
  // cycles of overcurrent seen with the output on
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) oc_cnt_r <= 0;
    else if (ovc_cmp && feed_output_en) oc_cnt_r <= oc_cnt_r + 1;
    else oc_cnt_r <= 0;
  end
  // rises seen in the current byte of a read frame
  always_ff @(posedge link_clk or negedge rst_n) begin
    if (!rst_n) bit_cnt_r <= 4'h0;
    else if (!rd_frame || bit_cnt_r == 4'h8) bit_cnt_r <= 4'h0;
    else bit_cnt_r <= bit_cnt_r + 4'h1;
  end
  sequence s_tripped;
    pri[2] && pri[0] && !feed_output_en;
  endsequence
  ////////////////////////////////////////
  a_irq_not_off: assert property (@(posedge clk) disable iff (!rst_n)
    $rose(pri[0]) && !pri[2] && !pri[6] && !pri[7] && !fault_irq |=> !fault_irq)
    else $error("irq raised by off flag");
  a_irq_follows: assert property (@(posedge clk) disable iff (!rst_n)
    pri[2] || pri[6] || pri[7] |-> ##[0:1] fault_irq) else $error("irq missing");
  a_overload_early: assert property (@(posedge clk) disable iff (!rst_n)
    oc_cnt_r == OC_HOLD - 2 |-> feed_output_en) else $error("overload trip early");
  a_overload_trip: assert property (@(posedge clk) disable iff (!rst_n)
    $fell(feed_output_en) && oc_cnt_r > 8 |-> ##[0:2] s_tripped)
    else $error("overload flags missing");
  a_overload_late: assert property (@(posedge clk) disable iff (!rst_n)
    oc_cnt_r <= OC_HOLD + 5) else $error("overload trip late");
  a_off_level_low: assert property (@(posedge clk) disable iff (!rst_n)
    !feed_output_en [*4] |-> pri[4] && pri[0]) else $error("off but level ok");
  a_level_low_set: assert property (@(posedge clk) disable iff (!rst_n)
    below85_cmp [*6] |-> pri[4]) else $error("level low not set");
  a_level_ok_clr: assert property (@(posedge clk) disable iff (!rst_n)
    (within90_cmp && !below85_cmp && feed_output_en) [*6] |-> !pri[4])
    else $error("level low not cleared");
  a_overheat_set: assert property (@(posedge clk) disable iff (!rst_n)
    hot_cmp [*6] |-> pri[6] && pri[0] && !feed_output_en) else $error("overheat missed");
  a_coax_source: assert property (@(posedge clk) disable iff (!rst_n)
    coax_src_en |-> !linear_reg_en) else $error("regulator on in coax test");
  a_coax_open_set: assert property (@(posedge clk) disable iff (!rst_n)
    (coax_src_en && above21_cmp && !below1995_cmp) [*6] |-> sec[0])
    else $error("coax open not set");
  a_coax_open_clr: assert property (@(posedge clk) disable iff (!rst_n)
    below1995_cmp [*6] |-> !sec[0]) else $error("coax open not cleared");
  a_tone_seen_set: assert property (@(posedge clk) disable iff (!rst_n)
    tone_out_cmp [*6] |-> sec[2]) else $error("tone not flagged");
  a_tone_seen_clr: assert property (@(posedge clk) disable iff (!rst_n)
    (!tone_local_en && !tone_rx_cmp && !tone_out_cmp) [*6] |-> !sec[2])
    else $error("tone flag stuck");
  a_unused_zero: assert property (@(posedge clk) disable iff (!rst_n)
    (pri & 8'h2a) == 8'h00 && (sec & 8'hfa) == 8'h00) else $error("unused bit set");
  a_ack_released: assert property (@(posedge link_clk) disable iff (!rst_n)
    rd_frame && bit_cnt_r == 4'h8 |-> !sda_oe) else $error("data held in ack slot");
endmodule

bind rsf_core rsf_chk #(.OC_HOLD(OC_HOLD)) chk (.*);

// [testbench/rsf_host.sv]
// host master model: clocks status reads over the link
// assumes an open-drain data wire with a pull-up; clock high when idle
`timescale 1ns/1ns
module rsf_host (
  // link
  output logic link_clk,
  output logic rd_frame,
  output logic sda_i,
  // device pin
  input wire logic sda_oe
);
  logic m_oe;
  logic [7:0] got [3];
  // wire is low if either side pulls
  assign sda_i = !(sda_oe || m_oe);
  initial begin
    link_clk = 1'b1;
    rd_frame = 1'b0;
    m_oe = 1'b0;
  end
  // n bytes, ack all but the last, clock stands still after
  task automatic rd(input int n);
    #7 rd_frame = 1'b1;
    #130 link_clk = 1'b0;
    for (int i = 0; i < n; i++) begin
      for (int b = 7; b >= 0; b--) begin
        #62 link_clk = 1'b1;
        got[i][b] = sda_i;
        #63 link_clk = 1'b0;
      end
      m_oe = (i < n - 1);
      #62 link_clk = 1'b1;
      #63 if (i < n - 1) link_clk = 1'b0;
      m_oe = 1'b0;
    end
    rd_frame = 1'b0;
  endtask
endmodule

// [testbench/rsf_core_tb.sv]
// self-checking bench for the regulator status flag block
// assumes the host model drives the link; the bench drives sensors
`timescale 1ns/1ns
module rsf_core_tb;
  localparam int OCH = 50;
  logic clk, rst_n, link_clk, rd_frame, sda_i, sda_o, sda_oe;
  logic ctl_write_done, output_on_ctl, coax_test_ctl, tone_local_en;
  logic ovc_cmp, hot_cmp, vin_low_cmp, below85_cmp, within90_cmp;
  logic above21_cmp, below1995_cmp, tone_out_cmp, tone_rx_cmp;
  logic feed_output_en, linear_reg_en, coax_src_en, fault_irq;
  logic [7:0] fault_status_primary, fault_status_secondary;
  int num_errors, comparisons;

  rsf_core #(.OC_HOLD(OCH)) uut (.*);
  rsf_host host (.link_clk(link_clk), .rd_frame(rd_frame), .sda_i(sda_i), .sda_oe(sda_oe));

  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  ////////////////////////////////////////
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    comparisons++;
    if (got !== exp) begin
      num_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic results;
    $display("errors %0d comparisons %0d", num_errors, comparisons);
    if (num_errors == 0 && comparisons > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic wr(input logic on, input logic cx);
    output_on_ctl = on;
    coax_test_ctl = cx;
    ctl_write_done = 1'b1;
    tick(1);
    ctl_write_done = 1'b0;
    tick(8);
  endtask
  task automatic rd(input int n);
    host.rd(n);
    tick(8);
  endtask
  task automatic wait_pri(input int b);
    int k;
    for (k = 0; k < OCH + 20 && fault_status_primary[b] !== 1'b1; k++) tick(1);
    if (k == OCH + 20) begin
      num_errors++;
      $display("wrong value at %0t: flag never set", $time);
      results;
    end
  endtask
  ////////////////////////////////////////
  task automatic t_enable;
    chk(fault_status_primary, 8'h11);
    chk({fault_status_secondary[7:1], fault_irq}, 8'h00);
    within90_cmp = 1'b1;
    below85_cmp = 1'b0;
    tick(6);
    chk(fault_status_primary, 8'h11);
    wr(1'b1, 1'b0);
    chk(fault_status_primary, 8'h00);
    within90_cmp = 1'b0;
    below85_cmp = 1'b1;
    tick(6);
    chk(fault_status_primary, 8'h10);
    below85_cmp = 1'b0;
    tick(6);
    chk(fault_status_primary, 8'h10);
    within90_cmp = 1'b1;
    tick(6);
    chk(fault_status_primary, 8'h00);
  endtask
  task automatic t_read;
    tone_local_en = 1'b1;
    tone_out_cmp = 1'b1;
    tick(6);
    chk(fault_status_secondary, 8'h04);
    rd(3);
    chk(host.got[0], 8'h00);
    chk(host.got[1], 8'h04);
    chk(host.got[2], 8'h00);
    rd(1);
    chk(host.got[0], 8'h00);
    chk({6'h0, sda_oe, sda_o}, 8'h00);
    tone_rx_cmp = 1'b1;
    tick(3);
    tone_local_en = 1'b0;
    tick(6);
    chk(fault_status_secondary, 8'h04);
    tone_rx_cmp = 1'b0;
    tone_out_cmp = 1'b0;
    tick(6);
    chk(fault_status_secondary, 8'h00);
  endtask
  task automatic t_overload;
    ovc_cmp = 1'b1;
    tick(OCH - 10);
    chk(fault_status_primary, 8'h00);
    wait_pri(2);
    tick(2);
    chk(fault_status_primary, 8'h15);
    chk({feed_output_en, fault_irq}, 8'h01);
    ovc_cmp = 1'b0;
    wr(1'b1, 1'b0);
    chk(fault_status_primary, 8'h15);
    rd(1);
    chk(host.got[0], 8'h15);
    chk(fault_status_primary, 8'h11);
    wr(1'b1, 1'b0);
    chk(fault_status_primary, 8'h00);
  endtask
  task automatic t_overheat;
    hot_cmp = 1'b1;
    tick(8);
    chk(fault_status_primary, 8'h51);
    rd(1);
    chk(fault_status_primary, 8'h51);
    hot_cmp = 1'b0;
    tick(8);
    chk(fault_status_primary, 8'h51);
    rd(1);
    chk(fault_status_primary, 8'h11);
    vin_low_cmp = 1'b1;
    tick(8);
    vin_low_cmp = 1'b0;
    tick(8);
    chk(fault_status_primary, 8'h91);
    rd(1);
    chk(fault_status_primary, 8'h11);
    chk({7'h0, feed_output_en}, 8'h00);
    wr(1'b1, 1'b0);
    chk({fault_status_primary[7:1], feed_output_en}, 8'h01);
  endtask
  task automatic t_coax;
    wr(1'b1, 1'b1);
    chk({feed_output_en, linear_reg_en, coax_src_en}, 8'h05);
    above21_cmp = 1'b1;
    below1995_cmp = 1'b0;
    tick(6);
    chk(fault_status_secondary, 8'h01);
    above21_cmp = 1'b0;
    below1995_cmp = 1'b1;
    tick(6);
    chk(fault_status_secondary, 8'h00);
    wr(1'b0, 1'b0);
    chk(fault_status_primary, 8'h11);
    chk({7'h0, fault_irq}, 8'h00);
  endtask
  ////////////////////////////////////////
  initial begin
    {ctl_write_done, output_on_ctl, coax_test_ctl, tone_local_en} = 4'h0;
    {ovc_cmp, hot_cmp, vin_low_cmp, within90_cmp, above21_cmp} = 5'h00;
    {tone_out_cmp, tone_rx_cmp} = 2'h0;
    below85_cmp = 1'b1;
    below1995_cmp = 1'b1;
    num_errors = 0;
    comparisons = 0;
    rst_n = 1'b0;
    repeat (12) @(posedge clk);
    #1 rst_n = 1'b1;
    tick(3);
    t_enable;
    t_read;
    t_overload;
    t_overheat;
    t_coax;
    results;
  end
endmodule
